// ===== sdcd_params.svh
// Constants for the DRAM command decoder: field positions, counts and reset values.
`ifndef SDCD_PARAMS_SVH
`define SDCD_PARAMS_SVH

`define SDCD_NBANK 8
`define SDCD_BA_W 3
`define SDCD_ADDR_W 16
`define SDCD_DQ_W 16
`define SDCD_NLANE 2
`define SDCD_NMR 4
`define SDCD_MR_W 16

// Address bits with a second meaning during column and precharge commands.
`define SDCD_AP_BIT 10
`define SDCD_BC_BIT 12

// Mode register numbers selected by the bank address during a mode register set.
`define SDCD_MR1 2'h1
`define SDCD_MR2 2'h2

// Termination fields: termination is disabled only while both fields are all zeros.
`define SDCD_MR1_RTT_B0 2
`define SDCD_MR1_RTT_B1 6
`define SDCD_MR1_RTT_B2 9
`define SDCD_MR2_RTT_B0 9
`define SDCD_MR2_RTT_B1 10

`define SDCD_MR_RST 16'h0000
`define SDCD_BANK_RST 8'h00

`endif

// ===== sdcd_pkg.sv
// Types shared by the DRAM command decoder: commands, power states and carriers.
package sdcd_pkg;

    typedef enum logic [3:0] {
        CMD_DES, CMD_NOP, CMD_ACT, CMD_PRE, CMD_PREA, CMD_WR, CMD_RD, CMD_MRS,
        CMD_REF, CMD_SRE, CMD_SRX, CMD_PDE, CMD_PDX, CMD_ZQL, CMD_ZQS, CMD_HOLD
    } sdcd_cmd_e;

    typedef enum logic [1:0] {
        PS_RUN, PS_PWRDN, PS_SELFREF
    } sdcd_pwr_e;

    // One decoded and accepted command as it is reported to the core side.
    typedef struct packed {
        sdcd_cmd_e cmd;
        logic [2:0] bank;
        logic [15:0] addr;
        logic auto_pre;
        logic burst8;
    } sdcd_cmdrep_s;

    // Write data for one link clock: the beat on the rising and on the falling strobe edge.
    typedef struct packed {
        logic [15:0] dq_rise;
        logic [15:0] dq_fall;
        logic [1:0] dm_rise;
        logic [1:0] dm_fall;
    } sdcd_wbeat_s;

    // Write data after masking, with one enable per byte lane and beat.
    typedef struct packed {
        logic valid;
        logic [15:0] dq_rise;
        logic [15:0] dq_fall;
        logic [1:0] be_rise;
        logic [1:0] be_fall;
    } sdcd_wout_s;

endpackage

// ===== sdcd_decoder.sv
// DRAM command decoder: command pins, bank state, masking and termination on the link clock.
`timescale 1ns/1ns
`default_nettype none
`include "sdcd_params.svh"

// Contract
// - Data moves on both strobe edges; write data is maskable per byte lane.
// - Lower and upper byte masks act independently of each other.
// - With a bank active and previous CKE high, mask high masks, low passes.
// - ODT registered high turns on termination for every DQ and strobe line.
// - ODT is ignored while both termination fields are programmed disabled.
// - RESET# low asynchronously resets the device; it stays high in operation.
// - Activate needs CKE high twice, the selected bank idle, and pins L L H H.
// - Precharge is legal anytime; A10 low closes one bank, high closes all.
// - Write is H L L on an active bank; A10 auto-precharge, A12 selects burst.
// - Read is H L H on an active bank; A10 and A12 as for writes.
// - Mode register set needs all banks idle; BA picks the register, address the code.
// - No-operation is CS low with H H H; deselect is CS high, rest ignored.
// - Refresh needs idle, CKE high twice, L L H; CKE falling means self-refresh entry.
// - Each command is decoded from the previous and the current CKE sample.
// - Power-down entry is CKE falling from idle with no-operation or deselect.
// - Power-down and self-refresh exit are CKE rising with no-operation or deselect.
// - ZQ calibration needs idle and CKE high twice, H H L; A10 picks long.
// - Any cycle with CS sampled high and CKE steady carries no command at all.
// - Write data of a lane is discarded while its mask is sampled high.
module sdcd_decoder
    import sdcd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ck,
    input wire logic reset_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [`SDCD_BA_W-1:0] ba,
    input wire logic [`SDCD_ADDR_W-1:0] addr,
    input wire logic odt,
    input wire logic wvalid,
    input wire sdcd_wbeat_s wbeat,
    output logic term_en,
    output sdcd_wout_s wout,
    output logic [`SDCD_NBANK-1:0] bank_open,
    output sdcd_pwr_e pwr_state,
    output logic cmd_valid,
    output sdcd_cmdrep_s cmd_rep,
    output logic cmd_miss,
    output logic [`SDCD_NBANK-1:0] core_bank_open,
    output logic core_idle
);

    ////////////////////////////////////////////////////////////////////////////////
    // Link side: command decode on the controller's clock.

    logic cke_prev_q;
    logic cke_seen_q;
    logic [`SDCD_NBANK-1:0] bank_q;
    sdcd_pwr_e pwr_q;
    logic [`SDCD_MR_W-1:0] mr_q [`SDCD_NMR];
    sdcd_cmd_e cmd_c;
    logic accept_c;
    logic all_idle_c;
    logic sel_open_c;
    logic rtt_on_c;
    logic link_rst_n_s1_q, link_rst_n_q;

    assign all_idle_c = (bank_q == `SDCD_BANK_RST);
    assign sel_open_c = bank_q[ba];

    always_ff @(posedge ck or negedge reset_n) begin
        if (!reset_n) begin
            link_rst_n_s1_q <= 1'b0;
            link_rst_n_q <= 1'b0;
        end else begin
            link_rst_n_s1_q <= 1'b1;
            link_rst_n_q <= link_rst_n_s1_q; // Reset enters at once but leaves two link edges later.
        end
    end

    // The previous CKE level is kept so that every command sees both samples.
    always_ff @(posedge ck or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            cke_prev_q <= 1'b0;
        end else begin
            cke_prev_q <= cke;
        end
    end

    always_comb begin
        cmd_c = CMD_HOLD;
        if (cke_prev_q && cke) begin
            if (cs_n) begin
                cmd_c = CMD_DES;
            end else begin
                unique case ({ras_n, cas_n, we_n})
                    3'b111: cmd_c = CMD_NOP;
                    3'b011: cmd_c = CMD_ACT;
                    3'b010: cmd_c = addr[`SDCD_AP_BIT] ? CMD_PREA : CMD_PRE;
                    3'b100: cmd_c = CMD_WR;
                    3'b101: cmd_c = CMD_RD;
                    3'b000: cmd_c = CMD_MRS;
                    3'b001: cmd_c = CMD_REF;
                    3'b110: cmd_c = addr[`SDCD_AP_BIT] ? CMD_ZQL : CMD_ZQS;
                endcase
            end
        end else if (cke_prev_q && !cke) begin
            if (cs_n || {ras_n, cas_n, we_n} == 3'b111) begin
                cmd_c = CMD_PDE;
            end else if ({ras_n, cas_n, we_n} == 3'b001) begin
                cmd_c = CMD_SRE;
            end
        end else if (!cke_prev_q && cke) begin
            if (cs_n || {ras_n, cas_n, we_n} == 3'b111) begin
                cmd_c = (pwr_q == PS_SELFREF) ? CMD_SRX : CMD_PDX;
            end
        end
    end

    // Commands that the present state does not allow are dropped; only precharge,
    // no-operation, deselect and the power-down and self-refresh exits are legal regardless of bank state.
    always_comb begin
        accept_c = 1'b0;
        unique case (cmd_c)
            CMD_DES, CMD_NOP, CMD_PRE, CMD_PREA: accept_c = (pwr_q == PS_RUN);
            CMD_ACT: accept_c = (pwr_q == PS_RUN) && !sel_open_c;
            CMD_WR, CMD_RD: accept_c = (pwr_q == PS_RUN) && sel_open_c;
            CMD_MRS, CMD_REF, CMD_ZQL, CMD_ZQS: accept_c = (pwr_q == PS_RUN) && all_idle_c;
            CMD_SRE, CMD_PDE: accept_c = (pwr_q == PS_RUN) && all_idle_c;
            CMD_SRX: accept_c = 1'b1;
            CMD_PDX: accept_c = (pwr_q == PS_PWRDN);
            CMD_HOLD: accept_c = 1'b0;
        endcase
    end

    // Auto-precharge closes the bank at once; the burst timing that delays it is
    // not modelled here, so a reopen in the next cycle is taken as legal.
    for (genvar b = 0; b < `SDCD_NBANK; b++) begin : g_bank
        always_ff @(posedge ck or negedge link_rst_n_q) begin
            if (!link_rst_n_q) begin
                bank_q[b] <= 1'b0;
            end else if (accept_c && ba == `SDCD_BA_W'(b)) begin
                if (cmd_c == CMD_ACT) begin
                    bank_q[b] <= 1'b1;
                end else if (cmd_c == CMD_PRE) begin
                    bank_q[b] <= 1'b0;
                end else if ((cmd_c == CMD_WR || cmd_c == CMD_RD) && addr[`SDCD_AP_BIT]) begin
                    bank_q[b] <= 1'b0;
                end else if (cmd_c == CMD_PREA) begin
                    bank_q[b] <= 1'b0;
                end
            end else if (accept_c && cmd_c == CMD_PREA) begin
                bank_q[b] <= 1'b0;
            end
        end
    end

    always_ff @(posedge ck or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            pwr_q <= PS_RUN;
        end else if (accept_c) begin
            unique case (cmd_c)
                CMD_PDE: pwr_q <= PS_PWRDN;
                CMD_SRE: pwr_q <= PS_SELFREF;
                CMD_PDX, CMD_SRX: pwr_q <= PS_RUN;
                default: pwr_q <= pwr_q;
            endcase
        end
    end

    for (genvar m = 0; m < `SDCD_NMR; m++) begin : g_mr
        always_ff @(posedge ck or negedge link_rst_n_q) begin
            if (!link_rst_n_q) begin
                mr_q[m] <= `SDCD_MR_RST;
            end else if (accept_c && cmd_c == CMD_MRS && ba == `SDCD_BA_W'(m)) begin
                mr_q[m] <= addr;
            end
        end
    end

    assign rtt_on_c = mr_q[`SDCD_MR1][`SDCD_MR1_RTT_B0] || mr_q[`SDCD_MR1][`SDCD_MR1_RTT_B1]
        || mr_q[`SDCD_MR1][`SDCD_MR1_RTT_B2] || mr_q[`SDCD_MR2][`SDCD_MR2_RTT_B0]
        || mr_q[`SDCD_MR2][`SDCD_MR2_RTT_B1];

    // Termination stays off after reset until CKE has been registered high once.
    always_ff @(posedge ck or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            cke_seen_q <= 1'b0;
            term_en <= 1'b0;
        end else begin
            cke_seen_q <= cke_seen_q || cke;
            term_en <= odt && rtt_on_c && (cke_seen_q || cke);
        end
    end

    // Masking needs an open bank and CKE high one clock earlier; outside that the
    // beat is dropped whole.
    always_ff @(posedge ck or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            wout <= '0;
        end else begin
            wout.valid <= wvalid && cke_prev_q && !all_idle_c;
            for (int l = 0; l < `SDCD_NLANE; l++) begin
                wout.be_rise[l] <= !wbeat.dm_rise[l];
                wout.be_fall[l] <= !wbeat.dm_fall[l];
                wout.dq_rise[8*l +: 8] <= wbeat.dm_rise[l] ? 8'h00 : wbeat.dq_rise[8*l +: 8];
                wout.dq_fall[8*l +: 8] <= wbeat.dm_fall[l] ? 8'h00 : wbeat.dq_fall[8*l +: 8];
            end
        end
    end

    assign bank_open = bank_q;
    assign pwr_state = pwr_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Crossing: accepted commands other than deselect and no-operation go to the core side by a toggle handshake.

    logic req_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic miss_q;
    sdcd_cmdrep_s hold_q;
    logic rep_c;
    logic ack_q;

    assign rep_c = accept_c && cmd_c != CMD_DES && cmd_c != CMD_NOP;

    always_ff @(posedge ck or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    // A command that arrives while the previous report is still in flight is
    // decoded normally but not reported; the sticky miss flag says so.
    always_ff @(posedge ck or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            req_q <= 1'b0;
            miss_q <= 1'b0;
            hold_q <= '0;
        end else if (rep_c && req_q == ack_s2_q) begin
            req_q <= !req_q;
            hold_q <= '{cmd: cmd_c, bank: ba, addr: addr, auto_pre: addr[`SDCD_AP_BIT],
                        burst8: addr[`SDCD_BC_BIT]};
        end else if (rep_c) begin
            miss_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Core side on clk.

    logic req_s1_q;
    logic req_s2_q;
    logic miss_s1_q;
    logic [`SDCD_NBANK-1:0] bank_s1_q;
    logic [`SDCD_NBANK-1:0] bank_s2_q;
    logic [`SDCD_NBANK-1:0] bank_s3_q, bank_core_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            miss_s1_q <= 1'b0;
            cmd_miss <= 1'b0;
            bank_s1_q <= `SDCD_BANK_RST;
            bank_s2_q <= `SDCD_BANK_RST;
            bank_s3_q <= `SDCD_BANK_RST;
            bank_core_q <= `SDCD_BANK_RST;
        end else begin
            req_s1_q <= req_q;
            req_s2_q <= req_s1_q;
            miss_s1_q <= miss_q;
            cmd_miss <= miss_s1_q;
            bank_s1_q <= bank_q;
            bank_s2_q <= bank_s1_q;
            bank_s3_q <= bank_s2_q;
            if (bank_s2_q == bank_s3_q) begin // Flags that flip together may land a cycle apart.
                bank_core_q <= bank_s2_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_q <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_rep <= '0;
        end else begin
            ack_q <= req_s2_q;
            cmd_valid <= req_s2_q != ack_q;
            if (req_s2_q != ack_q) begin
                cmd_rep <= hold_q;
            end
        end
    end

    assign core_bank_open = bank_core_q;
    assign core_idle = (bank_core_q == `SDCD_BANK_RST);

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_pd_enter;
        cke_prev_q && !cke && cs_n && all_idle_c && pwr_q == PS_RUN;
    endsequence

    sequence s_pd_exit;
        !cke_prev_q && cke && cs_n;
    endsequence

    property p_pd_cycle;
        @(posedge ck) disable iff (!reset_n)
        s_pd_enter ##1 (!cke)[*2] ##1 s_pd_exit |=> pwr_q == PS_RUN;
    endproperty

    pd_cycle_a: assert property (p_pd_cycle) else $error("power-down exit did not return to run");

    pd_enter_a: assert property (@(posedge ck) disable iff (!reset_n)
        s_pd_enter |=> pwr_q == PS_PWRDN) else $error("power-down entry missed");

    act_open_a: assert property (@(posedge ck) disable iff (!reset_n)
        cke_prev_q && cke && !cs_n && {ras_n, cas_n, we_n} == 3'b011 && pwr_q == PS_RUN
        |=> bank_q[$past(ba)]) else $error("activate did not open bank");

    pre_all_a: assert property (@(posedge ck) disable iff (!reset_n)
        cke_prev_q && cke && !cs_n && {ras_n, cas_n, we_n} == 3'b010 && addr[`SDCD_AP_BIT]
        && pwr_q == PS_RUN |=> bank_q == `SDCD_BANK_RST) else $error("precharge all left a bank open");

    cs_gate_a: assert property (@(posedge ck) disable iff (!reset_n)
        cs_n && cke_prev_q && cke |=> $stable(bank_q) && $stable(pwr_q) && $stable(req_q))
        else $error("deselect changed decoder state");

    rd_closed_a: assert property (@(posedge ck) disable iff (!reset_n)
        cke_prev_q && cke && !cs_n && {ras_n, cas_n, we_n} == 3'b101 && !bank_q[ba]
        |=> $stable(bank_q) && $stable(req_q)) else $error("read to idle bank accepted");

    mrs_busy_a: assert property (@(posedge ck) disable iff (!reset_n)
        cke_prev_q && cke && !cs_n && {ras_n, cas_n, we_n} == 3'b000 && !all_idle_c
        |=> mr_q[`SDCD_MR1] == $past(mr_q[`SDCD_MR1])) else $error("mode set while banks open");

    sr_enter_a: assert property (@(posedge ck) disable iff (!reset_n)
        cke_prev_q && !cke && !cs_n && {ras_n, cas_n, we_n} == 3'b001 && all_idle_c
        && pwr_q == PS_RUN |=> pwr_q == PS_SELFREF) else $error("self-refresh entry missed");

    odt_off_a: assert property (@(posedge ck) disable iff (!reset_n)
        !rtt_on_c |=> !term_en) else $error("termination on while disabled");

    odt_on_a: assert property (@(posedge ck) disable iff (!reset_n)
        odt && rtt_on_c && cke_seen_q |=> term_en) else $error("termination not enabled");

    lane_mask_a: assert property (@(posedge ck) disable iff (!link_rst_n_q)
        wbeat.dm_rise[1] && !wbeat.dm_rise[0] |=> !wout.be_rise[1] && wout.be_rise[0]
        && wout.dq_rise[15:8] == 8'h00) else $error("upper lane not masked alone");

    mask_gate_a: assert property (@(posedge ck) disable iff (!reset_n)
        wvalid && !cke_prev_q |=> !wout.valid) else $error("write beat passed with CKE low");

    rep_pulse_a: assert property (@(posedge clk) disable iff (rst)
        cmd_valid |=> !cmd_valid) else $error("report pulse longer than one cycle");

endmodule
`default_nettype wire

// ===== sdcd_ctrl_model.sv
// Memory controller model driving the command, termination and write data pins on the link clock.
`timescale 1ns/1ns
`default_nettype none
`include "sdcd_params.svh"
module sdcd_ctrl_model
    import sdcd_pkg::*;
(
    input wire logic ck,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [`SDCD_BA_W-1:0] ba,
    output logic [`SDCD_ADDR_W-1:0] addr,
    output logic odt,
    output logic wvalid,
    output sdcd_wbeat_s wbeat
);
    initial begin
        cke = 1'b0;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        ba = '0;
        addr = '0;
        odt = 1'b0;
        wvalid = 1'b0;
        wbeat = '0;
    end

    ////////////////////////////////////////
    // One command cycle, then deselect. Released lines show the inverse so stale values never look valid.
    task automatic cmd(input logic [3:0] p, input logic [2:0] b, input logic [15:0] a, input logic k);
        @(posedge ck);
        #1;
        {cs_n, ras_n, cas_n, we_n} = p;
        ba = b;
        addr = a;
        cke = k;
        @(posedge ck);
        #1;
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = ~p[2:0];
        ba = ~b;
        addr = ~a;
    endtask

    // Both strobe-edge beats of one link clock travel together.
    task automatic beat(input logic t, input logic v, input sdcd_wbeat_s w);
        @(posedge ck);
        #1;
        odt = t;
        wvalid = v;
        wbeat = w;
        @(posedge ck);
        #1;
        wvalid = 1'b0;
        wbeat = ~w;
    endtask
endmodule
`default_nettype wire

// ===== sdram_command_decoder_tb.sv
// Self-checking bench for the DRAM command decoder.
`timescale 1ns/1ns
`default_nettype none
`include "sdcd_params.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module sdram_command_decoder_tb
    import sdcd_pkg::*;
;
    logic clk = 1'b0;
    logic ck = 1'b0;
    logic rst = 1'b1;
    logic reset_n = 1'b0;
    wire logic cke, cs_n, ras_n, cas_n, we_n, odt, wvalid;
    wire logic [2:0] ba;
    wire logic [15:0] addr;
    wire sdcd_wbeat_s wbeat;
    wire logic term_en, cmd_valid, cmd_miss, core_idle;
    wire sdcd_wout_s wout;
    wire logic [7:0] bank_open, core_bank_open;
    wire sdcd_pwr_e pwr_state;
    wire sdcd_cmdrep_s cmd_rep;
    int fails = 0;
    int n_tests = 0;
    sdcd_wbeat_s w;

    always #5 clk = ~clk;
    // The link clock is offset so its edges never meet the core clock edges.
    initial begin
        #3;
        forever #15 ck = ~ck;
    end

    sdcd_ctrl_model ctrl_u (.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .ba(ba), .addr(addr), .odt(odt), .wvalid(wvalid), .wbeat(wbeat));
    sdcd_decoder dut_u (.clk(clk), .rst(rst), .ck(ck), .reset_n(reset_n), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .wvalid(wvalid),
        .wbeat(wbeat), .term_en(term_en), .wout(wout), .bank_open(bank_open), .pwr_state(pwr_state),
        .cmd_valid(cmd_valid), .cmd_rep(cmd_rep), .cmd_miss(cmd_miss), .core_bank_open(core_bank_open),
        .core_idle(core_idle));

    ////////////////////////////////////////
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Issue one command and watch the core side; CMD_DES expects no report, CMD_HOLD skips the check.
    task automatic run(input logic [3:0] p, input logic [2:0] b, input logic [15:0] a, input logic k,
        input sdcd_cmd_e e);
        logic seen;
        seen = 1'b0;
        ctrl_u.cmd(p, b, a, k);
        repeat (30) begin
            @(posedge clk);
            #1;
            if (cmd_valid === 1'b1) begin
                seen = 1'b1;
                if (e != CMD_HOLD) `CHK("cmd_rep.cmd", e, cmd_rep.cmd)
            end
        end
        if (e != CMD_HOLD) `CHK("report seen", e != CMD_DES, seen)
    endtask

    task automatic t_bank;
        run(4'h3, 3'h2, 16'h0000, 1'b1, CMD_ACT);
        `CHK("bank_open", 8'h04, bank_open)
        run(4'h3, 3'h2, 16'h0000, 1'b1, CMD_DES);
        run(4'h5, 3'h5, 16'h0000, 1'b1, CMD_DES);
        run(4'h4, 3'h2, 16'h1000, 1'b1, CMD_WR);
        `CHK("wr burst8", 1'b1, cmd_rep.burst8)
        `CHK("wr auto_pre", 1'b0, cmd_rep.auto_pre)
        `CHK("wr bank", 3'h2, cmd_rep.bank)
        run(4'h5, 3'h2, 16'h0400, 1'b1, CMD_RD);
        `CHK("rd burst8", 1'b0, cmd_rep.burst8)
        `CHK("rd closes", 8'h00, bank_open)
        run(4'h3, 3'h1, 16'h0000, 1'b1, CMD_ACT);
        run(4'h3, 3'h3, 16'h0000, 1'b1, CMD_ACT);
        `CHK("core_bank_open", 8'h0a, core_bank_open)
        run(4'h0, 3'h1, 16'h0004, 1'b1, CMD_DES);
        run(4'h6, 3'h0, 16'h0400, 1'b1, CMD_DES);
        run(4'h2, 3'h1, 16'h0000, 1'b1, CMD_PRE);
        `CHK("pre one", 8'h08, bank_open)
        run(4'h2, 3'h0, 16'h0400, 1'b1, CMD_PREA);
        `CHK("core_idle", 1'b1, core_idle)
    endtask

    task automatic t_cs;
        run(4'hb, 3'h3, 16'h0000, 1'b1, CMD_DES);
        `CHK("cs high", 8'h00, bank_open)
        run(4'h7, 3'h3, 16'h0000, 1'b1, CMD_DES);
    endtask

    task automatic t_mask;
        run(4'h3, 3'h0, 16'h0000, 1'b1, CMD_ACT);
        w = '{16'ha55a, 16'h3cc3, 2'h2, 2'h1};
        ctrl_u.beat(1'b0, 1'b1, w);
        `CHK("wout.valid", 1'b1, wout.valid)
        `CHK("be_rise", 2'h1, wout.be_rise)
        `CHK("be_fall", 2'h2, wout.be_fall)
        `CHK("dq_rise", 16'h005a, wout.dq_rise)
        `CHK("dq_fall", 16'h3c00, wout.dq_fall)
        run(4'h2, 3'h0, 16'h0400, 1'b1, CMD_PREA);
        ctrl_u.beat(1'b0, 1'b1, w);
        `CHK("valid idle", 1'b0, wout.valid)
    endtask

    task automatic t_odt;
        ctrl_u.beat(1'b1, 1'b0, w);
        `CHK("term off", 1'b0, term_en)
        run(4'h0, 3'h1, 16'h0004, 1'b1, CMD_MRS);
        ctrl_u.beat(1'b1, 1'b0, w);
        `CHK("term mr1", 1'b1, term_en)
        run(4'h0, 3'h2, 16'h0200, 1'b1, CMD_MRS);
        run(4'h0, 3'h1, 16'h0000, 1'b1, CMD_MRS);
        ctrl_u.beat(1'b1, 1'b0, w);
        `CHK("term mr2", 1'b1, term_en)
        run(4'h0, 3'h2, 16'h0000, 1'b1, CMD_MRS);
        ctrl_u.beat(1'b1, 1'b0, w);
        `CHK("term both off", 1'b0, term_en)
    endtask

    task automatic t_pwr;
        run(4'h7, 3'h0, 16'h0000, 1'b0, CMD_HOLD);
        `CHK("pde", PS_PWRDN, pwr_state)
        run(4'hf, 3'h0, 16'h0000, 1'b1, CMD_HOLD);
        `CHK("pdx", PS_RUN, pwr_state)
        run(4'h1, 3'h0, 16'h0000, 1'b0, CMD_HOLD);
        `CHK("sre", PS_SELFREF, pwr_state)
        run(4'h7, 3'h0, 16'h0000, 1'b1, CMD_HOLD);
        `CHK("srx", PS_RUN, pwr_state)
        ctrl_u.cmd(4'hf, 3'h0, 16'h0000, 1'b0);
        `CHK("pde deselect", PS_PWRDN, pwr_state)
        @(posedge ck);
        ctrl_u.cmd(4'hf, 3'h0, 16'h0000, 1'b1);
        @(posedge ck);
        #1;
        `CHK("pdx deselect", PS_RUN, pwr_state)
        run(4'h1, 3'h0, 16'h0000, 1'b1, CMD_REF);
        run(4'h6, 3'h0, 16'h0400, 1'b1, CMD_ZQL);
        run(4'h6, 3'h0, 16'h0000, 1'b1, CMD_ZQS);
    endtask

    // Device reset drops every open bank at once, without waiting for a link clock edge.
    task automatic t_rst;
        run(4'h3, 3'h4, 16'h0000, 1'b1, CMD_ACT);
        ctrl_u.cmd(4'h3, 3'h5, 16'h0000, 1'b1);
        ctrl_u.cmd(4'h3, 3'h6, 16'h0000, 1'b1);
        repeat (8) @(posedge clk);
        #1;
        `CHK("cmd_miss set", 1'b1, cmd_miss)
        `CHK("bank_open 456", 8'h70, bank_open)
        @(posedge clk);
        #1;
        reset_n = 1'b0;
        rst = 1'b1;
        #2;
        `CHK("reset banks", 8'h00, bank_open)
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        reset_n = 1'b1;
        run(4'hf, 3'h0, 16'h0000, 1'b1, CMD_HOLD);
        run(4'h3, 3'h4, 16'h0000, 1'b1, CMD_ACT);
        `CHK("cmd_miss", 1'b0, cmd_miss)
    endtask

    initial begin
        w = '0;
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        reset_n = 1'b1;
        run(4'hf, 3'h0, 16'h0000, 1'b1, CMD_HOLD);
        run(4'hf, 3'h0, 16'h0000, 1'b1, CMD_HOLD);
        t_bank();
        t_cs();
        t_mask();
        t_odt();
        t_pwr();
        t_rst();
        tally_and_finish();
    end

    // The whole run needs about 11 us; nine times that means a hang.
    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
